// ### logic/prmsc_regs.vh
// Constants of the pin, reset and mode-select control block.
// Included by every design file of the block; definitions only.
`ifndef PRMSC_REGS_VH
`define PRMSC_REGS_VH

// Register offsets
`define PRMSC_OFF_CAUSE 4'h0
`define PRMSC_OFF_CLKCTL 4'h1
`define PRMSC_OFF_STATUS 4'h2
`define PRMSC_OFF_PDIR 4'h3
`define PRMSC_OFF_PDATA 4'h4
`define PRMSC_OFF_PULL 4'h5
`define PRMSC_OFF_IRQCTL 4'h6
`define PRMSC_OFF_KBEDGE 4'h7
`define PRMSC_OFF_SWRST 4'h8

// Reset cause bits
`define PRMSC_CAUSE_POR 0
`define PRMSC_CAUSE_PIN 1
`define PRMSC_CAUSE_COP 2
`define PRMSC_CAUSE_ILOP 3
`define PRMSC_CAUSE_ILAD 4
`define PRMSC_CAUSE_LVD 5
`define PRMSC_CAUSE_SW 6

// Clock control fields
`define PRMSC_CLK_RANGE 0
`define PRMSC_CLK_STOPSELF 1
`define PRMSC_CLK_RST 8'h00

// IRQ control fields
`define PRMSC_IRQ_EN 0
`define PRMSC_IRQ_EDGE 1

// Status fields
`define PRMSC_ST_BGMODE 0
`define PRMSC_ST_SELFCLK 1
`define PRMSC_ST_INRST 2

// Reset values
`define PRMSC_RST_BYTE 8'h00
`define PRMSC_CAUSE_RST 8'h01

// Timing
`define PRMSC_RST_DRIVE_CYC 6'd34
`define PRMSC_BIT_CYC 5'd16
`define PRMSC_SPEEDUP_CYC 5'd1

`endif

// ### logic/prmsc_pin_arb.v
// Per-pin owner arbitration and pull direction for eight shared pins.
// Assumes enables from peripherals arrive on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "prmsc_regs.vh"

module prmsc_pin_arb (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Software port state
  input wire [7:0] port_dir,
  input wire [7:0] port_data,
  input wire [7:0] pull_en,
  input wire [7:0] kb_rise,
  // Peripheral requests, low and high priority
  input wire [7:0] alt1_en,
  input wire [7:0] alt1_oe,
  input wire [7:0] alt1_out,
  input wire [7:0] alt2_en,
  input wire [7:0] alt2_oe,
  input wire [7:0] alt2_out,
  input wire [7:0] kb_pin_mask,
  // Pad controls
  output reg [7:0] pad_oe,
  output reg [7:0] pad_out,
  output reg [7:0] pad_pu,
  output reg [7:0] pad_pd
);

  wire [7:0] oe_v;
  wire [7:0] out_v;
  wire [7:0] pu_v;
  wire [7:0] pd_v;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      wire pull_w;
      wire down_w;
      assign oe_v[i] = alt2_en[i] ? alt2_oe[i] :
                       alt1_en[i] ? alt1_oe[i] : port_dir[i];
      assign out_v[i] = alt2_en[i] ? alt2_out[i] :
                        alt1_en[i] ? alt1_out[i] : port_data[i];
      assign pull_w = pull_en[i] & ~oe_v[i];
      assign down_w = kb_pin_mask[i] & alt2_en[i] & kb_rise[i];
      assign pu_v[i] = pull_w & ~down_w;
      assign pd_v[i] = pull_w & down_w;
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pad_oe <= 8'h00;
      pad_out <= 8'h00;
      pad_pu <= 8'h00;
      pad_pd <= 8'h00;
    end else begin
      pad_oe <= oe_v;
      pad_out <= out_v;
      pad_pu <= pu_v;
      pad_pd <= pd_v;
    end
  end

endmodule // prmsc_pin_arb
`default_nettype wire

// ### logic/prmsc_bgd_phy.v
// Debug serial pin driver: pseudo open-drain with speed-up pulse.
// Assumes the debug controller supplies one bit per request.
`timescale 1ns/10ps
`default_nettype none
`include "prmsc_regs.vh"

module prmsc_bgd_phy (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Controller side
  input wire enable,
  input wire tx_req,
  input wire tx_bit,
  output reg busy,
  // Pin side
  output reg pin_out,
  output reg pin_oe
);

  reg [4:0] cnt_q;
  reg bit_q;

  always @(posedge clk_sys) begin
    if (!reset_n || !enable) begin
      cnt_q <= 5'h00;
      bit_q <= 1'b1;
      busy <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (!busy) begin
      if (tx_req) begin
        busy <= 1'b1;
        bit_q <= tx_bit;
        cnt_q <= 5'h00;
        pin_out <= 1'b0;
        pin_oe <= 1'b1;
      end
    end else begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == `PRMSC_BIT_CYC - 5'h01) begin
        busy <= 1'b0;
        pin_oe <= 1'b0;
        pin_out <= 1'b0;
      end else if (cnt_q == 5'h03 && bit_q) begin
        pin_out <= 1'b1;
        pin_oe <= 1'b1;
      end else if (cnt_q == 5'h03 + `PRMSC_SPEEDUP_CYC && bit_q) begin
        pin_out <= 1'b0;
        pin_oe <= 1'b0;
      end else if (cnt_q == 5'h0b && !bit_q) begin
        pin_out <= 1'b1;
        pin_oe <= 1'b1;
      end else if (cnt_q == 5'h0b + `PRMSC_SPEEDUP_CYC && !bit_q) begin
        pin_out <= 1'b0;
        pin_oe <= 1'b0;
      end
    end
  end

endmodule // prmsc_bgd_phy
`default_nettype wire

// ### logic/prmsc_top.v
// Pin, reset and mode-select control of a small microcontroller.
// Assumes pads resolve the three-signal pins; pins are asynchronous.
// Behaviour
// - Drive reset pin low 34 cycles
// - Record reset cause flag
// - Sample mode pin at reset rise
// - Mode input in reset, debug after
// - Debug bit lasts sixteen clocks
// - Pseudo open-drain with speed-up pulses
// - Run self-clocked source out of reset
// - Self clock selectable for stop recovery
// - Control bit selects oscillator range
// - IRQ pin feeds interrupt and branches
// - Pins reset to hi-z, no pull
// - Peripheral drives enable, direction picks read
// - Pull enable active whenever input
// - Keyboard rising edge uses pulldown
// - IRQ rising edge uses pulldown
// - Highest priority module owns pin
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "prmsc_regs.vh"

module prmsc_top (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Internal reset sources and stop wake, one-cycle pulses
  input wire por_evt,
  input wire cop_evt,
  input wire ilop_evt,
  input wire ilad_evt,
  input wire lvd_evt,
  input wire stop_wake,
  // Reset pin
  input wire reset_pin_in,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  output reg sys_reset_q,
  // Debug / mode-select pin
  input wire dbg_pin_in,
  output reg dbg_pin_out,
  output reg dbg_pin_oe,
  output reg dbg_pin_pu,
  output reg bg_mode_q,
  // Debug controller
  input wire dbg_tx_req,
  input wire dbg_tx_bit,
  output reg dbg_busy_q,
  output reg dbg_rx_q,
  // Clock selection
  output reg self_clk_sel_q,
  output reg osc_range_q,
  // External interrupt pin
  input wire irq_pin_in,
  output reg irq_req_q,
  output reg irq_level_q,
  output reg irq_pu,
  output reg irq_pd,
  // Shared pins
  input wire [7:0] pad_in,
  input wire [7:0] alt1_en,
  input wire [7:0] alt1_oe,
  input wire [7:0] alt1_out,
  input wire [7:0] alt2_en,
  input wire [7:0] alt2_oe,
  input wire [7:0] alt2_out,
  output wire [7:0] pad_oe,
  output wire [7:0] pad_out,
  output wire [7:0] pad_pu,
  output wire [7:0] pad_pd,
  output reg [7:0] pad_in_q
);

  // Keyboard-capable pins: bits 2, 3 and 4
  localparam [7:0] KB_MASK = 8'h1c;
  localparam ST_RUN = 2'd0;
  localparam ST_DRIVE = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [1:0] st_q;
  reg [5:0] cnt_q;
  reg [7:0] cause_q;
  reg [7:0] cause_acc_q;
  reg [7:0] clkctl_q;
  reg [7:0] pdir_q;
  reg [7:0] pdata_q;
  reg [7:0] pull_q;
  reg [7:0] kbedge_q;
  reg [1:0] irqctl_q;
  reg sw_rst_q;
  reg rst_s1_q, rst_s2_q;
  reg dbg_s1_q, dbg_s2_q;
  reg irq_s1_q, irq_s2_q, irq_prev_q;
  reg [7:0] pad_s1_q;
  reg por_done_q;
  wire phy_out, phy_oe, phy_busy;
  wire irq_edge_w;
  wire [7:0] rd_w;
  wire [7:0] status_w;

  // Two-flop synchronisers for pins
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      dbg_s1_q <= 1'b1;
      dbg_s2_q <= 1'b1;
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
      pad_s1_q <= 8'h00;
      pad_in_q <= 8'h00;
    end else begin
      rst_s1_q <= reset_pin_in;
      rst_s2_q <= rst_s1_q;
      dbg_s1_q <= dbg_pin_in;
      dbg_s2_q <= dbg_s1_q;
      irq_s1_q <= irq_pin_in;
      irq_s2_q <= irq_s1_q;
      pad_s1_q <= pad_in;
      pad_in_q <= pad_s1_q;
    end
  end

  // Reset sequencer
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= ST_DRIVE;
      cnt_q <= 6'h00;
      cause_acc_q <= `PRMSC_CAUSE_RST;
      cause_q <= `PRMSC_RST_BYTE;
      por_done_q <= 1'b0;
      sys_reset_q <= 1'b1;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      bg_mode_q <= 1'b0;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (por_evt | cop_evt | ilop_evt | ilad_evt | lvd_evt |
              sw_rst_q | !rst_s2_q) begin
            cause_acc_q <= {1'b0, sw_rst_q, lvd_evt, ilad_evt, ilop_evt,
                            cop_evt, !rst_s2_q & ~(sw_rst_q | lvd_evt |
                            ilad_evt | ilop_evt | cop_evt | por_evt),
                            por_evt};
            st_q <= ST_DRIVE;
            cnt_q <= 6'h00;
            sys_reset_q <= 1'b1;
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b1;
          end
        end
        ST_DRIVE: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == `PRMSC_RST_DRIVE_CYC - 6'h01) begin
            reset_pin_oe <= 1'b0;
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rst_s2_q) begin
            st_q <= ST_RUN;
            sys_reset_q <= 1'b0;
            cause_q <= cause_acc_q;
            por_done_q <= 1'b1;
            bg_mode_q <= ~dbg_s2_q;
          end
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end

  // Registers written by software
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      clkctl_q <= `PRMSC_CLK_RST;
      pdir_q <= `PRMSC_RST_BYTE;
      pdata_q <= `PRMSC_RST_BYTE;
      pull_q <= `PRMSC_RST_BYTE;
      kbedge_q <= `PRMSC_RST_BYTE;
      irqctl_q <= 2'b00;
      sw_rst_q <= 1'b0;
    end else if (sys_reset_q) begin
      pdir_q <= `PRMSC_RST_BYTE;
      pull_q <= `PRMSC_RST_BYTE;
      kbedge_q <= `PRMSC_RST_BYTE;
      irqctl_q <= 2'b00;
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= reg_wr && reg_addr == `PRMSC_OFF_SWRST && reg_wdata[0];
      if (reg_wr) begin
        case (reg_addr)
          `PRMSC_OFF_CLKCTL: clkctl_q <= reg_wdata;
          `PRMSC_OFF_PDIR: pdir_q <= reg_wdata;
          `PRMSC_OFF_PDATA: pdata_q <= reg_wdata;
          `PRMSC_OFF_PULL: pull_q <= reg_wdata;
          `PRMSC_OFF_IRQCTL: irqctl_q <= reg_wdata[1:0];
          `PRMSC_OFF_KBEDGE: kbedge_q <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Clock selection
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      self_clk_sel_q <= 1'b1;
      osc_range_q <= 1'b0;
    end else begin
      osc_range_q <= clkctl_q[`PRMSC_CLK_RANGE];
      if (sys_reset_q)
        self_clk_sel_q <= 1'b1;
      else if (stop_wake)
        self_clk_sel_q <= clkctl_q[`PRMSC_CLK_STOPSELF];
      else if (reg_wr && reg_addr == `PRMSC_OFF_CLKCTL)
        self_clk_sel_q <= 1'b0;
    end
  end

  // External interrupt pin
  assign irq_edge_w = irqctl_q[`PRMSC_IRQ_EDGE] ? (irq_s2_q & ~irq_prev_q)
                                                : (~irq_s2_q & irq_prev_q);
  always @(posedge clk_sys) begin
    if (!reset_n || sys_reset_q) begin
      irq_prev_q <= 1'b1;
      irq_req_q <= 1'b0;
      irq_level_q <= 1'b0;
      irq_pu <= 1'b0;
      irq_pd <= 1'b0;
    end else begin
      irq_prev_q <= irq_s2_q;
      irq_req_q <= irqctl_q[`PRMSC_IRQ_EN] & irq_edge_w;
      irq_level_q <= irqctl_q[`PRMSC_IRQ_EN] & irq_s2_q;
      irq_pu <= irqctl_q[`PRMSC_IRQ_EN] & ~irqctl_q[`PRMSC_IRQ_EDGE];
      irq_pd <= irqctl_q[`PRMSC_IRQ_EN] & irqctl_q[`PRMSC_IRQ_EDGE];
    end
  end

  // Debug pin: mode input in reset, serial after
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      dbg_pin_out <= 1'b0;
      dbg_pin_oe <= 1'b0;
      dbg_pin_pu <= 1'b1;
      dbg_busy_q <= 1'b0;
      dbg_rx_q <= 1'b1;
    end else begin
      dbg_pin_out <= sys_reset_q ? 1'b0 : phy_out;
      dbg_pin_oe <= sys_reset_q ? 1'b0 : phy_oe;
      dbg_pin_pu <= 1'b1;
      dbg_busy_q <= phy_busy;
      dbg_rx_q <= dbg_s2_q;
    end
  end

  prmsc_bgd_phy u_phy (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .enable(~sys_reset_q),
    .tx_req(dbg_tx_req),
    .tx_bit(dbg_tx_bit),
    .busy(phy_busy),
    .pin_out(phy_out),
    .pin_oe(phy_oe)
  );

  prmsc_pin_arb u_arb (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .port_dir(pdir_q),
    .port_data(pdata_q),
    .pull_en(pull_q),
    .kb_rise(kbedge_q),
    .alt1_en(alt1_en),
    .alt1_oe(alt1_oe),
    .alt1_out(alt1_out),
    .alt2_en(alt2_en),
    .alt2_oe(alt2_oe),
    .alt2_out(alt2_out),
    .kb_pin_mask(KB_MASK),
    .pad_oe(pad_oe),
    .pad_out(pad_out),
    .pad_pu(pad_pu),
    .pad_pd(pad_pd)
  );

  assign rd_w = (pdir_q & pdata_q) | (~pdir_q & pad_in_q);
  assign status_w = {5'h00, sys_reset_q, self_clk_sel_q, bg_mode_q};

  // Read data, one cycle after strobe
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PRMSC_OFF_CAUSE: reg_rdata <= cause_q;
        `PRMSC_OFF_CLKCTL: reg_rdata <= clkctl_q;
        `PRMSC_OFF_STATUS: reg_rdata <= status_w;
        `PRMSC_OFF_PDIR: reg_rdata <= pdir_q;
        `PRMSC_OFF_PDATA: reg_rdata <= rd_w;
        `PRMSC_OFF_PULL: reg_rdata <= pull_q;
        `PRMSC_OFF_IRQCTL: reg_rdata <= {6'h00, irqctl_q};
        `PRMSC_OFF_KBEDGE: reg_rdata <= kbedge_q;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // prmsc_top
`default_nettype wire

// ### sim/prmsc_checker.sv
// Concurrent checks on the pin, reset and mode-select control top.
// Bound to prmsc_top from the bench; sees top-level ports only.
`timescale 1ns/10ps
`default_nettype none
module prmsc_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Observed ports
  input wire logic cop_evt,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic sys_reset_q,
  input wire logic dbg_pin_out,
  input wire logic dbg_pin_oe,
  input wire logic bg_mode_q,
  input wire logic dbg_busy_q,
  input wire logic irq_pu,
  input wire logic irq_pd,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pu,
  input wire logic [7:0] pad_pd
);
  logic [7:0] drv_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Counts consecutive reset pin drive cycles
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !reset_pin_oe) drv_q <= 8'h00;
    else drv_q <= drv_q + 8'h01;
  end
  drive_length_a: assert property ($fell(reset_pin_oe) |-> drv_q == 8'h22)
    else $error("reset pin drive length wrong");
  drive_low_a: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  event_drive_a: assert property (cop_evt && !sys_reset_q |=> reset_pin_oe)
    else $error("reset pin not driven after event");
  mode_hold_a: assert property ($past(!sys_reset_q) && !sys_reset_q |-> $stable(bg_mode_q))
    else $error("start-up mode changed in run");
  mode_input_a: assert property (sys_reset_q |-> !dbg_pin_oe)
    else $error("mode pin driven in reset");
  pads_reset_a: assert property (sys_reset_q && $past(sys_reset_q) |-> pad_oe == 8'h00 && pad_pu == 8'h00)
    else $error("shared pads not idle in reset");
  pull_excl_a: assert property (!(irq_pu && irq_pd) && (pad_pu & pad_pd) == 8'h00)
    else $error("pull-up and pull-down together");
  bit_time_a: assert property ($rose(dbg_busy_q) |-> dbg_busy_q [*8] ##1 dbg_busy_q [*8] ##1 !dbg_busy_q)
    else $error("debug bit time wrong");
  speedup_a: assert property (dbg_pin_oe && dbg_pin_out |=> !dbg_pin_oe)
    else $error("speed-up pulse too long");
  cover property ($fell(sys_reset_q));
  cover property ($rose(bg_mode_q));
  cover property ($rose(dbg_busy_q));
  cover property ($fell(reset_pin_oe));
endmodule // prmsc_checker
`default_nettype wire

// ### sim/prmsc_host_model.sv
// Board reset switch and debug host on the reset and mode pins.
// Resolves each pin from every party's drive and the board pull-ups.
`timescale 1ns/10ps
`default_nettype none
module prmsc_host_model (
  // Bench commands
  input wire logic pull_rst,
  input wire logic hold_bg,
  // Device drive
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic dbg_pin_out,
  input wire logic dbg_pin_oe,
  // Resolved levels
  output logic reset_pin_in,
  output logic dbg_pin_in
);
  assign reset_pin_in = !(pull_rst || (reset_pin_oe && !reset_pin_out));
  assign dbg_pin_in = dbg_pin_oe ? dbg_pin_out : !hold_bg;
endmodule // prmsc_host_model
`default_nettype wire

// ### sim/prmsc_top_bench.sv
// Self-checking bench of the pin, reset and mode-select control block.
// Host model closes the pins; checker is bound at the foot.
`timescale 1ns/10ps
`default_nettype none
`include "prmsc_regs.vh"
module prmsc_top_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, d, pdir, pdat, pul, kbr;
  logic stop_wake = 1'b0, irq_pin_in = 1'b1, hold_bg = 1'b1;
  logic dbg_tx_req = 1'b0, dbg_tx_bit = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0] pad_in = 8'h00, alt1_en = 8'h00, alt1_oe = 8'h00;
  logic [7:0] alt1_out = 8'h00, alt2_en = 8'h00, alt2_oe = 8'h00;
  logic [7:0] alt2_out = 8'h00;
  logic [31:0] p;
  integer errors = 0, total_checks = 0, k, i, lo, hi, bz;
  wire logic por_evt, pull_rst, cop_evt, ilop_evt, ilad_evt, lvd_evt;
  wire logic reset_pin_in, reset_pin_out, reset_pin_oe, sys_reset_q;
  wire logic dbg_pin_in, dbg_pin_out, dbg_pin_oe, dbg_pin_pu, bg_mode_q;
  wire logic dbg_busy_q, self_clk_sel_q, osc_range_q;
  wire logic irq_level_q, irq_pu, irq_pd, irq_req_q, dbg_rx_q;
  wire logic [7:0] reg_rdata, pad_oe, pad_out, pad_pu, pad_pd;
  assign {lvd_evt, ilad_evt, ilop_evt, cop_evt, pull_rst, por_evt} = ev;
  always #20 clk_sys = ~clk_sys;
  prmsc_top u_dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .por_evt, .cop_evt, .ilop_evt, .ilad_evt,
    .lvd_evt, .stop_wake, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .sys_reset_q, .dbg_pin_in, .dbg_pin_out, .dbg_pin_oe, .dbg_pin_pu,
    .bg_mode_q, .dbg_tx_req, .dbg_tx_bit, .dbg_busy_q, .dbg_rx_q,
    .self_clk_sel_q, .osc_range_q, .irq_pin_in, .irq_req_q,
    .irq_level_q, .irq_pu, .irq_pd, .pad_in, .alt1_en, .alt1_oe,
    .alt1_out, .alt2_en, .alt2_oe, .alt2_out, .pad_oe, .pad_out, .pad_pu,
    .pad_pd, .pad_in_q());
  prmsc_host_model u_host (.pull_rst, .hold_bg, .reset_pin_out,
    .reset_pin_oe, .dbg_pin_out, .dbg_pin_oe, .reset_pin_in, .dbg_pin_in);
  task chk(input logic [31:0] e, input logic [31:0] s, input string n);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task run_wait;
    for (int n = 0; n < 200 && sys_reset_q !== 1'b0; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(0, sys_reset_q, "reset released");
  endtask
  function automatic logic [31:0] pads_exp;
    logic [7:0] oe, pd;
    oe = alt2_en & alt2_oe | ~alt2_en & (alt1_en & alt1_oe | ~alt1_en & pdir);
    pd = pul & ~oe & 8'h1c & alt2_en & kbr;
    pads_exp = {oe, alt2_en & alt2_out | ~alt2_en & (alt1_en & alt1_out
      | ~alt1_en & pdat), pul & ~oe & ~pd, pd};
  endfunction
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(40 * 6000);
    errors++;
    wrap_up;
  end
  initial begin
    k = $urandom(70);
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    run_wait;
    chk(1, bg_mode_q, "bg_mode_q");
    hold_bg <= 1'b0;
    rd(`PRMSC_OFF_CAUSE, d);
    chk(`PRMSC_CAUSE_RST, d, "cause");
    rd(`PRMSC_OFF_STATUS, d);
    chk(8'h03, d, "status");
    chk(1, bg_mode_q, "bg_mode_q held");
    chk(1, dbg_pin_pu, "debug pin pull-up");
    // Every reset source in turn
    for (k = 0; k < 7; k++) begin
      if (k == 6) wr(`PRMSC_OFF_SWRST, 8'h01);
      else begin
        ev <= 6'h01 << k;
        @(posedge clk_sys);
        ev <= 6'h00;
      end
      repeat (4) @(posedge clk_sys);
      run_wait;
      rd(`PRMSC_OFF_CAUSE, d);
      chk(8'h01 << k, d, "cause");
      chk(0, bg_mode_q, "bg_mode_q");
    end
    wr(`PRMSC_OFF_CLKCTL, 8'h03);
    rd(`PRMSC_OFF_CLKCTL, d);
    chk(8'h03, d, "clkctl");
    chk(2'b10, {osc_range_q, self_clk_sel_q}, "clock select");
    stop_wake <= 1'b1;
    @(posedge clk_sys);
    stop_wake <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(1, self_clk_sel_q, "stop wake clock");
    for (k = 0; k < 2; k++) begin
      wr(`PRMSC_OFF_IRQCTL, k ? 8'h03 : 8'h01);
      irq_pin_in <= 1'($urandom);
      repeat (4) @(posedge clk_sys);
      #1;
      chk({k[0], ~k[0]}, {irq_pd, irq_pu}, "irq pull");
      chk(irq_pin_in, irq_level_q, "irq level");
    end
    irq_pin_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    irq_pin_in <= 1'b1;
    lo = 0;
    repeat (6) begin
      @(posedge clk_sys);
      #1;
      lo += irq_req_q;
    end
    chk(1, lo, "irq rising edge");
    // One and zero bits on the debug pin
    for (k = 0; k < 2; k++) begin
      dbg_tx_bit <= ~k[0];
      dbg_tx_req <= 1'b1;
      @(posedge clk_sys);
      dbg_tx_req <= 1'b0;
      lo = 0;
      hi = 0;
      bz = 0;
      repeat (24) begin
        @(posedge clk_sys);
        #1;
        lo += !dbg_pin_in;
        hi += dbg_pin_oe && dbg_pin_out;
        bz += dbg_busy_q;
      end
      chk(k ? 12 : 4, lo, "debug low time");
      chk(1, hi, "speed-up pulse");
      chk(16, bz, "bit time");
      chk(1, dbg_rx_q, "debug pin idle");
    end
    for (i = 0; i < 16; i++) begin
      pdir = 8'($urandom);
      pdat = 8'($urandom);
      pul = i < 2 ? 8'hff : 8'($urandom);
      kbr = 8'($urandom);
      wr(`PRMSC_OFF_PDIR, pdir);
      wr(`PRMSC_OFF_PDATA, pdat);
      wr(`PRMSC_OFF_PULL, pul);
      wr(`PRMSC_OFF_KBEDGE, kbr);
      {alt1_en, alt1_oe, alt1_out, alt2_oe} <= $urandom;
      {alt2_out, pad_in} <= 16'($urandom);
      alt2_en <= i < 2 ? 8'hff : 8'($urandom);
      repeat (4) @(posedge clk_sys);
      #1;
      p = pads_exp();
      chk(p, {pad_oe, pad_out, pad_pu, pad_pd}, "pads");
      rd(`PRMSC_OFF_PDATA, d);
      chk(pdir & pdat | ~pdir & pad_in, d, "port data");
    end
    wrap_up;
  end
endmodule // prmsc_top_bench
bind prmsc_top prmsc_checker u_chk (.clk_sys, .reset_n, .cop_evt,
  .reset_pin_out, .reset_pin_oe, .sys_reset_q, .dbg_pin_out, .dbg_pin_oe,
  .bg_mode_q, .dbg_busy_q, .irq_pu, .irq_pd, .pad_oe, .pad_pu, .pad_pd);
`default_nettype wire
